// *** rtl/cfg_ctl_top.sv ***
/*
 * configuration control sequencer: power-up, scheme capture, open-drain
 * fault and status handling, reconfiguration request, option bits over
 * AXI4-Lite, done and init-done pins, user I/O enable, stream decompression.
 * assumes pins arrive asynchronously and the stream is on the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module cfg_ctl_top (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic I_SCHEME_SELECT_HI,
   input wire logic I_SCHEME_SELECT_LO,
   input wire logic I_CHIP_OUTPUT_ENABLE_PIN,
   input wire logic I_RECONFIG_REQ,
   input wire logic I_FAULT_FLAG_LINE,
   output logic O_FAULT_FLAG_LINE,
   output logic O_FAULT_FLAG_LINE_OE,
   input wire logic I_CONFIG_DONE_LINE,
   output logic O_CONFIG_DONE_LINE,
   output logic O_CONFIG_DONE_LINE_OE,
   input wire logic I_INIT_DONE_PIN,
   output logic O_INIT_DONE_PIN,
   output logic O_INIT_DONE_PIN_OE,
   input wire logic I_USER_PIN_OUT,
   input wire logic I_USER_PIN_OE,
   output logic O_USER_IO_EN,
   input wire logic [7:0] I_CFG_DATA,
   input wire logic I_CFG_VALID,
   input wire logic I_CFG_LAST,
   input wire logic I_CFG_ERR,
   output logic O_CFG_READY,
   output logic [7:0] O_CFG_BYTE,
   output logic O_CFG_BYTE_VALID
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [6:0] pins;
   logic rc_q;
   wire sel_lo = pins[0];
   wire sel_hi = pins[1];
   wire rc_s = pins[2];
   wire fault_s = pins[3];
   wire chip_oe_s = pins[4];
   wire done_s = pins[5];
   wire init_pin_s = pins[6];

   // every pin level the sequencer uses comes through here
   pin_sync #(
      .WIDTH(7),
      .RST_VAL(cfg_ctl_pkg::SYNC_RESET)
   ) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_async({I_INIT_DONE_PIN, I_CONFIG_DONE_LINE, I_CHIP_OUTPUT_ENABLE_PIN,
                I_FAULT_FLAG_LINE, I_RECONFIG_REQ, I_SCHEME_SELECT_HI,
                I_SCHEME_SELECT_LO}),
      .o_level(pins)
   );

   // edges of the synchronised reconfiguration request
   wire rc_fall = rc_q & ~rc_s;
   wire rc_rise = ~rc_q & rc_s;

   // ****************************************
   // option and status registers
   // ****************************************
   cfg_ctl_pkg::state_t st;
   cfg_ctl_pkg::state_t next_st;
   logic [3:0] ctrl;
   logic [1:0] scheme;
   logic err_flag;
   logic [cfg_ctl_pkg::TIMER_W-1:0] timer;
   logic [31:0] status;

   wire opt_oe = ctrl[cfg_ctl_pkg::CTRL_OE_BIT];
   wire opt_init = ctrl[cfg_ctl_pkg::CTRL_INIT_BIT];
   wire opt_comp = ctrl[cfg_ctl_pkg::CTRL_COMP_BIT];
   wire opt_auto = ctrl[cfg_ctl_pkg::CTRL_AUTO_BIT];

   always_comb begin
      status = 32'h00000000;
      status[cfg_ctl_pkg::STAT_STATE_LSB +: 3] = st;
      status[cfg_ctl_pkg::STAT_SCHEME_LSB +: 2] = scheme;
      status[cfg_ctl_pkg::STAT_ERR_BIT] = err_flag;
      status[cfg_ctl_pkg::STAT_PIN_BIT] = init_pin_s;
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   logic aw_got;
   logic w_got;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // word decode, shared by both channels
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr[7:2] == off[7:2]);
   endfunction : hit

   wire do_wr = aw_got & w_got & ~O_BVALID;
   wire next_aw_got = do_wr ? 1'b0 : aw_got | (I_AWVALID & O_AWREADY);
   wire next_w_got = do_wr ? 1'b0 : w_got | (I_WVALID & O_WREADY);
   wire wr_ctrl = hit(aw_addr, cfg_ctl_pkg::ADDR_CTRL);
   wire wr_ok = wr_ctrl | hit(aw_addr, cfg_ctl_pkg::ADDR_STATUS);
   wire rd_ctrl = hit(I_ARADDR, cfg_ctl_pkg::ADDR_CTRL);
   wire rd_stat = hit(I_ARADDR, cfg_ctl_pkg::ADDR_STATUS);
   wire ar_take = I_ARVALID & O_ARREADY;
   wire [31:0] rd_word = rd_ctrl ? {28'h0000000, ctrl} : rd_stat ? status : 32'h00000000;

   // write side: address and data may come in either order
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {aw_got, w_got, O_BVALID} <= 3'h0;
         {O_AWREADY, O_WREADY} <= 2'h3;
         O_BRESP <= cfg_ctl_pkg::RESP_OKAY;
         {aw_addr, w_strb, w_data} <= 44'h00000000000;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         O_AWREADY <= ~next_aw_got;
         O_WREADY <= ~next_w_got;
         if (I_AWVALID & O_AWREADY) aw_addr <= I_AWADDR;
         if (I_WVALID & O_WREADY) {w_strb, w_data} <= {I_WSTRB, I_WDATA};
         if (do_wr) O_BRESP <= wr_ok ? cfg_ctl_pkg::RESP_OKAY : cfg_ctl_pkg::RESP_SLVERR;
         if (do_wr) O_BVALID <= 1'b1;
         else if (I_BREADY) O_BVALID <= 1'b0;
      end
   end

   // option bits; only byte lane 0 holds anything
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) ctrl <= cfg_ctl_pkg::CTRL_RESET;
      else if (do_wr & wr_ctrl & w_strb[0]) ctrl <= w_data[3:0];
   end

   // read side: one read in flight, answered the cycle after it is taken
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ARREADY <= 1'b1;
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h00000000;
         O_RRESP <= cfg_ctl_pkg::RESP_OKAY;
      end else if (ar_take) begin
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b1;
         O_RDATA <= rd_word;
         O_RRESP <= (rd_ctrl | rd_stat) ? cfg_ctl_pkg::RESP_OKAY : cfg_ctl_pkg::RESP_SLVERR;
      end else if (O_RVALID & I_RREADY) begin
         O_ARREADY <= 1'b1;
         O_RVALID <= 1'b0;
      end
   end

   // ****************************************
   // configuration stream
   // ****************************************
   logic dec_done;
   wire scheme_ok = (scheme == cfg_ctl_pkg::SCHEME_AS) | (scheme == cfg_ctl_pkg::SCHEME_PS);
   wire comp_bad = opt_comp & ~scheme_ok & I_CFG_VALID;
   wire cfg_err = I_CFG_ERR | comp_bad;

   cfg_decomp u_dec (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_en(st == cfg_ctl_pkg::S_CFG),
      .i_compress(opt_comp),
      .i_data(I_CFG_DATA),
      .i_valid(I_CFG_VALID),
      .i_last(I_CFG_LAST),
      .o_ready(O_CFG_READY),
      .o_data(O_CFG_BYTE),
      .o_valid(O_CFG_BYTE_VALID),
      .o_done(dec_done)
   );

   // ****************************************
   // sequencer
   // ****************************************
   wire timer_end_por = (timer == cfg_ctl_pkg::TIMER_W'(cfg_ctl_pkg::POR_CYC - 1));
   wire timer_end_err = (timer >= cfg_ctl_pkg::TIMER_W'(cfg_ctl_pkg::ERR_PULSE_CYC - 1));
   wire timer_end_init = (timer == cfg_ctl_pkg::TIMER_W'(cfg_ctl_pkg::INIT_CYC - 1));

   // a falling request beats everything else, whatever the state
   always_comb begin
      next_st = st;
      case (st)
         cfg_ctl_pkg::S_POR: if (timer_end_por) next_st = cfg_ctl_pkg::S_WAIT;
         cfg_ctl_pkg::S_WAIT: if (rc_s & fault_s) next_st = cfg_ctl_pkg::S_CFG;
         cfg_ctl_pkg::S_CFG: begin
            if (~fault_s | cfg_err) next_st = cfg_ctl_pkg::S_ERR;
            else if (dec_done) next_st = cfg_ctl_pkg::S_INIT;
         end
         cfg_ctl_pkg::S_INIT: begin
            if (~fault_s) next_st = cfg_ctl_pkg::S_ERR;
            else if (done_s & timer_end_init) next_st = cfg_ctl_pkg::S_USER;
         end
         cfg_ctl_pkg::S_USER: next_st = st;
         cfg_ctl_pkg::S_ERR: begin
            if (opt_auto & timer_end_err) next_st = cfg_ctl_pkg::S_WAIT;
         end
         cfg_ctl_pkg::S_HOLD: if (rc_rise) next_st = cfg_ctl_pkg::S_WAIT;
         default: next_st = cfg_ctl_pkg::S_POR;
      endcase
      if (rc_fall) next_st = cfg_ctl_pkg::S_HOLD;
   end

   // state, timer and the scheme captured when configuration begins
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st <= cfg_ctl_pkg::S_POR;
         timer <= '0;
         rc_q <= 1'b1;
         scheme <= cfg_ctl_pkg::SCHEME_AS;
         err_flag <= 1'b0;
      end else begin
         st <= next_st;
         rc_q <= rc_s;
         // init cycles only count while the done line is seen high
         if (next_st != st || (st == cfg_ctl_pkg::S_INIT && !done_s)) timer <= '0;
         else if (timer != '1) timer <= timer + 1'b1;
         if (next_st == cfg_ctl_pkg::S_CFG && st != cfg_ctl_pkg::S_CFG) begin
            scheme <= {sel_hi, sel_lo};
         end
         if (next_st == cfg_ctl_pkg::S_ERR) err_flag <= 1'b1;
         else if (st == cfg_ctl_pkg::S_HOLD && rc_rise) err_flag <= 1'b0;
      end
   end

   // ****************************************
   // pin drivers, registered from the next state
   // ****************************************
   wire nx_por = (next_st == cfg_ctl_pkg::S_POR);
   wire nx_err = (next_st == cfg_ctl_pkg::S_ERR);
   wire nx_cfg = (next_st == cfg_ctl_pkg::S_CFG) | (next_st == cfg_ctl_pkg::S_INIT);
   wire nx_user = (next_st == cfg_ctl_pkg::S_USER);
   wire nx_done = nx_user | (next_st == cfg_ctl_pkg::S_INIT);
   // user drive is cut when the chip-wide enable is on and its pin is low
   wire user_ok = nx_user & ~(opt_oe & ~chip_oe_s);

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {O_FAULT_FLAG_LINE, O_CONFIG_DONE_LINE, O_INIT_DONE_PIN} <= 3'h0;
         {O_FAULT_FLAG_LINE_OE, O_CONFIG_DONE_LINE_OE} <= 2'h3;
         {O_INIT_DONE_PIN_OE, O_USER_IO_EN} <= 2'h0;
      end else begin
         O_FAULT_FLAG_LINE_OE <= nx_por | nx_err;
         O_CONFIG_DONE_LINE_OE <= ~nx_done;
         O_USER_IO_EN <= user_ok;
         // option on: open-drain low while configuring, else user pin
         O_INIT_DONE_PIN <= opt_init ? 1'b0 : I_USER_PIN_OUT;
         O_INIT_DONE_PIN_OE <= opt_init ? nx_cfg : (user_ok & I_USER_PIN_OE);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   property p_chip_oe;
      O_USER_IO_EN && $past(opt_oe) |-> $past(chip_oe_s);
   endproperty
   a_chip_oe: assert property (p_chip_oe) else $error("user I/O on with OE pin low");

   property p_init_low;
      st == cfg_ctl_pkg::S_CFG && $past(opt_init) |-> O_INIT_DONE_PIN_OE && !O_INIT_DONE_PIN;
   endproperty
   a_init_low: assert property (p_init_low) else $error("init pin not low in config");

   property p_init_rel;
      st == cfg_ctl_pkg::S_USER && $past(opt_init) |-> !O_INIT_DONE_PIN_OE;
   endproperty
   a_init_rel: assert property (p_init_rel) else $error("init pin held in user mode");

   property p_por;
      $fell(st == cfg_ctl_pkg::S_POR) |-> $past(timer) == cfg_ctl_pkg::TIMER_W'(cfg_ctl_pkg::POR_CYC - 1)
         && !O_FAULT_FLAG_LINE_OE;
   endproperty
   a_por: assert property (p_por) else $error("power-up release time wrong");

   property p_ext_fault;
      st == cfg_ctl_pkg::S_CFG && !fault_s && !rc_fall |=> st == cfg_ctl_pkg::S_ERR;
   endproperty
   a_ext_fault: assert property (p_ext_fault) else $error("external fault missed");

   property p_user_hold;
      st == cfg_ctl_pkg::S_USER && !rc_fall |=> st == cfg_ctl_pkg::S_USER && $stable(scheme);
   endproperty
   a_user_hold: assert property (p_user_hold) else $error("user mode disturbed");

   property p_reset_edge;
      rc_fall |=> st == cfg_ctl_pkg::S_HOLD ##1 !O_USER_IO_EN && !O_INIT_DONE_PIN_OE;
   endproperty
   a_reset_edge: assert property (p_reset_edge) else $error("request fall not obeyed");

   property p_start_edge;
      st == cfg_ctl_pkg::S_HOLD && rc_rise |=> st == cfg_ctl_pkg::S_WAIT;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("request rise not obeyed");

   property p_hold_tri;
      st == cfg_ctl_pkg::S_HOLD |-> !O_USER_IO_EN && !O_INIT_DONE_PIN_OE;
   endproperty
   a_hold_tri: assert property (p_hold_tri) else $error("I/O driven while held");

   property p_auto;
      st == cfg_ctl_pkg::S_ERR && opt_auto |-> ##[1:11] st != cfg_ctl_pkg::S_ERR;
   endproperty
   a_auto: assert property (p_auto) else $error("auto restart too slow");

   property p_halt;
      st == cfg_ctl_pkg::S_ERR && !opt_auto && !rc_fall |=> st == cfg_ctl_pkg::S_ERR
         && O_FAULT_FLAG_LINE_OE;
   endproperty
   a_halt: assert property (p_halt) else $error("error state left on its own");

   c_user: cover property (st == cfg_ctl_pkg::S_INIT ##1 st == cfg_ctl_pkg::S_USER);
   c_err: cover property (st == cfg_ctl_pkg::S_CFG ##1 st == cfg_ctl_pkg::S_ERR);
   c_restart: cover property (st == cfg_ctl_pkg::S_ERR ##1 st == cfg_ctl_pkg::S_WAIT);
   c_hold: cover property (st == cfg_ctl_pkg::S_HOLD ##1 st == cfg_ctl_pkg::S_WAIT);
endmodule : cfg_ctl_top
`default_nettype wire

// *** rtl/cfg_ctl_pkg.sv ***
/*
 * constants shared by the configuration control block: timing counts,
 * register offsets and fields, scheme codes and sequencer states.
 * assumes a 100 MHz core clock.
 */
package cfg_ctl_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_RELEASE_NS = 5000;  // power-up release, longest time
   localparam int POR_CYC = POR_RELEASE_NS / CLK_PERIOD_NS;  // rounds down
   localparam int ERR_PULSE_NS = 100;     // auto-restart low pulse, least time
   localparam int ERR_PULSE_CYC = (ERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_CYC = 8;           // initialization clock cycles
   localparam int TIMER_W = 16;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CTRL_OE_BIT = 0;        // chip-wide output enable option
   localparam int CTRL_INIT_BIT = 1;      // init-done output option
   localparam int CTRL_COMP_BIT = 2;      // decompression option
   localparam int CTRL_AUTO_BIT = 3;      // auto restart on error
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_SCHEME_LSB = 4;
   localparam int STAT_ERR_BIT = 8;
   localparam int STAT_PIN_BIT = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // schemes and states
   // ****************************************
   localparam logic [1:0] SCHEME_AS = 2'h0;
   localparam logic [1:0] SCHEME_PS = 2'h1;
   localparam logic [6:0] SYNC_RESET = 7'h3C;  // request, fault, chip OE and done lines idle high; init pin resets low

   typedef enum logic [2:0] {
      S_POR = 3'h0,
      S_WAIT = 3'h1,
      S_CFG = 3'h2,
      S_INIT = 3'h3,
      S_USER = 3'h4,
      S_ERR = 3'h5,
      S_HOLD = 3'h6
   } state_t;

endpackage : cfg_ctl_pkg

// *** rtl/pin_sync.sv ***
/*
 * three-flop synchroniser for pin levels; a new level is taken once the
 * second and third flops agree.
 * assumes inputs are asynchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   wire [WIDTH-1:0] agree = ~(s2 ^ s3);

   if (WIDTH < 1) begin : g_chk
      $error("pin_sync needs WIDTH of at least 1");
   end

   // s1 feeds s2 only; the filter looks at s2 and s3
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         o_level <= RST_VAL;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         o_level <= (s2 & agree) | (o_level & ~agree);
      end
   end
endmodule : pin_sync
`default_nettype wire

// *** rtl/cfg_decomp.sv ***
/*
 * configuration byte stream path: pass-through, or run-length tokens
 * of count then value, emitted count+1 times.
 * assumes the source holds valid and data until taken.
 */
`timescale 1ns/1ns
`default_nettype none
module cfg_decomp (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic i_compress,
   input wire logic [7:0] i_data,
   input wire logic i_valid,
   input wire logic i_last,
   output logic o_ready,
   output logic [7:0] o_data,
   output logic o_valid,
   output logic o_done
);
   logic phase;
   logic last_tok;
   logic [7:0] count;
   logic [7:0] value;
   logic [8:0] rep;

   // token decode; ready drops while a run is being emitted
   wire take = i_valid & o_ready;
   wire plain = take & ~i_compress;
   wire load = take & i_compress & phase;
   wire [8:0] next_rep = load ? {1'b0, count} + 9'h001 :
                         (rep != 9'h000) ? rep - 9'h001 : 9'h000;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {phase, last_tok, o_ready, o_valid, o_done} <= 5'h00;
         {count, value, o_data} <= 24'h000000;
         rep <= 9'h000;
      end else if (!i_en) begin
         {phase, last_tok, o_ready, o_valid, o_done} <= 5'h00;
         rep <= 9'h000;
      end else begin
         rep <= next_rep;
         o_ready <= (next_rep == 9'h000);
         if (take & i_compress & ~phase) count <= i_data;
         if (take & i_compress) phase <= ~phase;
         if (load) value <= i_data;
         if (load) last_tok <= i_last;
         o_valid <= plain | (rep != 9'h000);
         o_data <= plain ? i_data : value;
         o_done <= (plain & i_last) | ((rep == 9'h001) & last_tok);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_plain;
      i_en && plain |=> o_valid && o_data == $past(i_data);
   endproperty
   a_plain: assert property (p_plain) else $error("byte not passed through");

   property p_run;
      i_en && load ##1 i_en |=> o_valid && o_data == $past(i_data, 2);
   endproperty
   a_run: assert property (p_run) else $error("run value not emitted");
endmodule : cfg_decomp
`default_nettype wire

// *** verif/cfg_host.sv ***
/*
 * far-side model: resolves the three pulled-up open-drain wires.
 * assumes the bench drives the request pin and the byte stream itself.
 */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// wire resolution
// ****************************************
module cfg_host (
   input wire logic i_fault_oe,
   input wire logic i_hold,
   input wire logic i_done_oe,
   input wire logic i_init_oe,
   input wire logic i_init_out,
   output logic o_fault,
   output logic o_done,
   output logic o_init
);
   // pull-ups win unless someone sinks; the memory may hold fault low too
   assign o_fault = ~(i_fault_oe | i_hold);
   assign o_done = ~i_done_oe;
   assign o_init = i_init_oe ? i_init_out : 1'h1;
endmodule : cfg_host
`default_nettype wire

// *** verif/tb.sv ***
/*
 * self-checking bench for the configuration control block.
 * assumes the open-drain wires are resolved by the host model.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ****************************************
   // signals
   // ****************************************
   logic clk, rst_n, awv, wv, bry, arv, rry, shi, slo, coe, rcfg, xf, cv, cl;
   logic awr, wr, bv, arr, rv, foe, dnoe, io, iooe, uen, crdy, ovld, fl, dl, il, uo;
   logic [7:0] awa, ara, cd, v, ob;
   logic [31:0] wd, rd;
   logic [1:0] bresp, rresp;
   int seed = 40053;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   logic [33:0] eq[$];
   logic [31:0] mq[$];
   logic [7:0] sq[$];
   cfg_ctl_top cfg_ctl_top_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awa),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
      .O_WREADY(wr), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara),
      .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rresp), .O_RVALID(rv),
      .I_RREADY(rry), .I_SCHEME_SELECT_HI(shi), .I_SCHEME_SELECT_LO(slo),
      .I_CHIP_OUTPUT_ENABLE_PIN(coe), .I_RECONFIG_REQ(rcfg), .I_FAULT_FLAG_LINE(fl),
      .O_FAULT_FLAG_LINE(), .O_FAULT_FLAG_LINE_OE(foe), .I_CONFIG_DONE_LINE(dl),
      .O_CONFIG_DONE_LINE(), .O_CONFIG_DONE_LINE_OE(dnoe), .I_INIT_DONE_PIN(il),
      .O_INIT_DONE_PIN(io), .O_INIT_DONE_PIN_OE(iooe), .I_USER_PIN_OUT(uo),
      .I_USER_PIN_OE(uo), .O_USER_IO_EN(uen), .I_CFG_DATA(cd), .I_CFG_VALID(cv),
      .I_CFG_LAST(cl), .I_CFG_ERR(1'h0), .O_CFG_READY(crdy), .O_CFG_BYTE(ob),
      .O_CFG_BYTE_VALID(ovld));
   cfg_host cfg_host_inst (.i_fault_oe(foe), .i_hold(xf), .i_done_oe(dnoe),
      .i_init_oe(iooe), .i_init_out(io), .o_fault(fl), .o_done(dl), .o_init(il));
   // ****************************************
   // checking helpers
   // ****************************************
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic final_report();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // sample at the falling edge so settled outputs never race the driver
   always @(negedge clk) begin
      if (rv & rry) begin
         chk({rresp, rd & mq.pop_front()}, eq.pop_front());
      end
      if (ovld) chk(ob, sq.pop_front());
   end
   // hang guard: a few thousand cycles cover the whole sequence
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // bus and pin tasks
   // ****************************************
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb_;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      tb_ = 1'h0;
      while (!tb_) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr;
         tb_ = bv;
         if (tb_) chk(bresp, er);
         @(posedge clk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
      end
      // bready stays high so a following call never re-drives it in one step
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
      logic ta, tr;
      eq.push_back(e);
      mq.push_back(m);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      tr = 1'h0;
      while (!tr) begin
         @(negedge clk);
         ta = arv & arr;
         tr = rv;
         @(posedge clk);
         if (ta) arv <= 1'h0;
      end
   endtask : axi_rd
   task automatic st(input logic [31:0] e, input logic [31:0] m);
      axi_rd(cfg_ctl_pkg::ADDR_STATUS, {cfg_ctl_pkg::RESP_OKAY, e}, m);
   endtask : st
   // valid stays up between bytes; the caller drops it after the last one
   task automatic put(input logic [7:0] d, input logic l);
      logic t;
      cd <= d;
      cl <= l;
      cv <= 1'h1;
      t = 1'h0;
      while (!t) begin
         @(negedge clk);
         t = crdy;
         @(posedge clk);
      end
   endtask : put
   task automatic to_user();
      for (int n = 0; n < 100 && !uen; n++) @(negedge clk);
      chk({uen, dnoe, iooe}, 3'h4);
      @(posedge clk);
   endtask : to_user
   task automatic reconf(input logic h);
      rcfg <= 1'h0;
      shi <= h;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(uen, 1'h0);
      @(posedge clk);
      rcfg <= 1'h1;
      repeat (10) @(posedge clk);
   endtask : reconf
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_n, awv, wv, bry, arv, rry, shi, xf, cv, cl, uo, awa, ara, cd, wd} = '0;
      {coe, rcfg} = 2'h3;
      slo = 1'($random(seed));
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      chk({foe, uen}, 2'h2);
      repeat (490) @(posedge clk);
      @(negedge clk);
      chk(foe, 1'h1);
      repeat (12) @(posedge clk);
      chk(foe, 1'h0);
      axi_rd(cfg_ctl_pkg::ADDR_CTRL, 34'h0, 32'hFFFFFFFF);
      axi_wr(cfg_ctl_pkg::ADDR_CTRL, 32'h2, cfg_ctl_pkg::RESP_OKAY);
      axi_rd(cfg_ctl_pkg::ADDR_CTRL, 34'h2, 32'hFFFFFFFF);
      axi_wr(8'h08, 32'h1, cfg_ctl_pkg::RESP_SLVERR);
      axi_rd(8'h0C, {cfg_ctl_pkg::RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
      st({27'h0, slo, 4'h2}, 32'h37);
      @(negedge clk);
      chk({iooe, io, dnoe}, 3'h5);
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         sq.push_back(v);
         put(v, i == 5);
      end
      cv <= 1'h0;
      to_user();
      // memory pulls the fault line and offers its stream again
      {xf, cv, shi} <= 3'h7;
      repeat (10) @(posedge clk);
      chk(crdy, 1'h0);
      {xf, cv} <= 2'h0;
      st({27'h0, slo, 4'h4}, 32'h37);
      axi_wr(cfg_ctl_pkg::ADDR_CTRL, 32'h1, cfg_ctl_pkg::RESP_OKAY);
      {coe, uo} <= 2'h1;
      repeat (6) @(posedge clk);
      chk({uen, iooe}, 2'h0);
      coe <= 1'h1;
      repeat (6) @(posedge clk);
      chk({uen, iooe, io}, 3'h7);
      axi_wr(cfg_ctl_pkg::ADDR_CTRL, 32'h6, cfg_ctl_pkg::RESP_OKAY);
      reconf(1'h0);
      st(32'h2, 32'h107);
      v = 8'($random(seed));
      repeat (3) sq.push_back(v);
      put(8'h02, 1'h0);
      put(v, 1'h1);
      cv <= 1'h0;
      to_user();
      reconf(1'h1);
      cv <= 1'h1;
      repeat (8) @(posedge clk);
      cv <= 1'h0;
      chk(foe, 1'h1);
      st(32'h105, 32'h107);
      reconf(1'h0);
      st(32'h2, 32'h107);
      xf <= 1'h1;
      repeat (6) @(posedge clk);
      xf <= 1'h0;
      st(32'h105, 32'h107);
      axi_wr(cfg_ctl_pkg::ADDR_CTRL, 32'h8, cfg_ctl_pkg::RESP_OKAY);
      reconf(1'h0);
      xf <= 1'h1;
      repeat (6) @(posedge clk);
      xf <= 1'h0;
      repeat (40) @(posedge clk);
      st(32'h2, 32'h7);
      final_report();
   end
endmodule : tb
`default_nettype wire
